// file: logic/dwd_regs.vh
`ifndef DWD_REGS_VH
`define DWD_REGS_VH

// ****************************************
// Frame layout
// ****************************************
`define DWD_FRAME_BITS 6'h18
`define DWD_RW_BIT 23
`define DWD_DEV_HI 22
`define DWD_DEV_LO 21
`define DWD_DREG_HI 20
`define DWD_DREG_LO 18
`define DWD_CH_HI 17
`define DWD_CH_LO 16
`define DWD_CREG_HI 15
`define DWD_CREG_LO 13

// ****************************************
// Register selects
// ****************************************
`define DWD_DREG_OFFSET 3'h4
`define DWD_DREG_OFFSET_ALL 3'h5
`define DWD_DREG_CLEAR 3'h6
`define DWD_DREG_CTRL 3'h7
`define DWD_CREG_SLEW 3'h0
`define DWD_CREG_MAIN 3'h1
`define DWD_CREG_CHAN 3'h2
`define DWD_CREG_BOOST 3'h3
`define DWD_CREG_SOFT 3'h4

// ****************************************
// Main control fields and resets
// ****************************************
`define DWD_IDLE_BIT 12
`define DWD_STAT_BIT 11
`define DWD_WD_ON_BIT 10
`define DWD_TO_HI 9
`define DWD_TO_LO 8
`define DWD_SHORT_BIT 6
`define DWD_OUT_ALL_BIT 5
`define DWD_BOOST_ALL_BIT 4
`define DWD_OFFSET_RST 16'h8000
`define DWD_CLEAR_RST 16'h0000
`define DWD_MAIN_RST 1'b0

// ****************************************
// Timing
// ****************************************
`define DWD_CLK_KHZ 100000
`define DWD_TO0_MS 5
`define DWD_TO1_MS 10
`define DWD_TO2_MS 100
`define DWD_TO3_MS 200
`endif

// file: logic/dwd_sync2.v
module dwd_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_q;

  // First stage is read only by the second
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= INIT;
      q_out <= INIT;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule // dwd_sync2

// file: logic/dwd_write_decode.v
`include "dwd_regs.vh"

module dwd_write_decode #(
  parameter [31:0] WD_CYC0 = `DWD_TO0_MS * `DWD_CLK_KHZ,
  parameter [31:0] WD_CYC1 = `DWD_TO1_MS * `DWD_CLK_KHZ,
  parameter [31:0] WD_CYC2 = `DWD_TO2_MS * `DWD_CLK_KHZ,
  parameter [31:0] WD_CYC3 = `DWD_TO3_MS * `DWD_CLK_KHZ
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire sclk_in,
  input wire sync_n_in,
  input wire sdin_in,
  input wire device_select_hi_in,
  input wire device_select_lo_in,
  input wire idle_pin_in,
  input wire [15:0] status_in,
  output wire sdo_out,
  output reg sdo_oe_out,
  output wire [63:0] offset_out,
  output wire [63:0] clear_out,
  output reg idle_output_state_out,
  output reg status_on_write_out,
  output reg watchdog_on_out,
  output reg [1:0] timeout_sel_out,
  output reg short_limit_sel_out,
  output reg global_output_on_out,
  output reg [3:0] global_boost_power_out,
  output reg idle_level_out,
  output reg wd_expired_out,
  output reg ctrl_wr_out,
  output reg [2:0] ctrl_sel_out,
  output reg [1:0] ctrl_chan_out,
  output reg [12:0] ctrl_data_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Link strobes idle high, so their stages reset high as well and
  // no false edge follows reset
  wire [2:0] link_s;
  wire [1:0] dev_s;
  wire idle_pin_s;
  wire sclk_s = link_s[0];
  wire sync_n_s = link_s[1];
  wire sdin_s = link_s[2];

  dwd_sync2 #(
    .W(3),
    .INIT(3'h3)
  ) u_sync_link (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({sdin_in, sync_n_in, sclk_in}),
    .q_out(link_s)
  );

  // Straps are static in use but still come from outside the clock
  dwd_sync2 #(
    .W(2),
    .INIT(2'h0)
  ) u_sync_strap (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({device_select_hi_in, device_select_lo_in}),
    .q_out(dev_s)
  );

  dwd_sync2 #(
    .W(1),
    .INIT(1'b0)
  ) u_sync_idle (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(idle_pin_in),
    .q_out(idle_pin_s)
  );

  // ****************************************
  // Link edges and shifter
  // ****************************************
  reg sclk_q;
  reg sync_q;
  reg [23:0] shift_q;
  reg [5:0] bit_cnt_q;
  reg [23:0] sdo_sh_q;

  // Last seen levels of the two link strobes, reset to their idle level
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_q <= 1'b1;
    end else begin
      sync_q <= sync_n_s;
    end
  end

  wire sclk_fall = sclk_q & ~sclk_s;
  wire sclk_rise = ~sclk_q & sclk_s;
  wire frame_start = sync_q & ~sync_n_s;
  wire frame_end = ~sync_q & sync_n_s;

  // Bits are taken on falling link clock edges, MSB first
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift_q <= 24'h000000;
      bit_cnt_q <= 6'h00;
    end else if (frame_start) begin
      bit_cnt_q <= 6'h00;
    end else if (!sync_n_s && sclk_fall) begin
      shift_q <= {shift_q[22:0], sdin_s};
      if (bit_cnt_q != 6'h3F) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // ****************************************
  // Frame decode
  // ****************************************
  wire [1:0] f_dev = shift_q[`DWD_DEV_HI:`DWD_DEV_LO];
  wire [2:0] f_dreg = shift_q[`DWD_DREG_HI:`DWD_DREG_LO];
  wire [1:0] f_ch = shift_q[`DWD_CH_HI:`DWD_CH_LO];
  wire [2:0] f_creg = shift_q[`DWD_CREG_HI:`DWD_CREG_LO];
  wire [15:0] f_data = shift_q[15:0];

  wire len_ok = (bit_cnt_q == `DWD_FRAME_BITS);
  wire is_write = !shift_q[`DWD_RW_BIT];
  wire dev_ok = (f_dev == dev_s);

  // A short or long frame, a read or another device's frame is dropped
  wire commit = frame_end && len_ok && is_write && dev_ok;
  wire is_ctrl = (f_dreg == `DWD_DREG_CTRL);
  wire is_main = is_ctrl && (f_creg == `DWD_CREG_MAIN);
  wire is_other_ctrl = is_ctrl &&
    ((f_creg == `DWD_CREG_SLEW) || (f_creg == `DWD_CREG_CHAN) ||
     (f_creg == `DWD_CREG_BOOST) || (f_creg == `DWD_CREG_SOFT));
  // Sub-selects 101 to 111 raise neither enable
  wire main_we = commit && is_main;
  wire ctrl_we = commit && is_other_ctrl;

  // ****************************************
  // Offset and clear registers
  // ****************************************
  // Offset codes are passed on unchanged as straight binary
  wire do_offset = commit && (f_dreg == `DWD_DREG_OFFSET);
  wire do_offset_all = commit && (f_dreg == `DWD_DREG_OFFSET_ALL);
  wire do_clear = commit && (f_dreg == `DWD_DREG_CLEAR);
  wire [3:0] ch_hit = 4'h1 << f_ch;

  reg [15:0] offset_q [0:3];
  reg [15:0] clear_q [0:3];
  wire [3:0] offset_we;
  wire [3:0] clear_we;
  integer i;
  genvar g;

  // Per-channel enables; the broadcast select hits all four at once,
  // so every channel takes the same code in the same cycle
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      assign offset_we[g] = do_offset_all || (do_offset && ch_hit[g]);
      assign clear_we[g] = do_clear && ch_hit[g];
      assign offset_out[16 * g +: 16] = offset_q[g];
      assign clear_out[16 * g +: 16] = clear_q[g];
    end
  endgenerate

  always @(posedge clk_in) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (!rst_n_in) begin
        offset_q[i] <= `DWD_OFFSET_RST;
        clear_q[i] <= `DWD_CLEAR_RST;
      end else begin
        if (offset_we[i]) begin
          offset_q[i] <= f_data;
        end
        if (clear_we[i]) begin
          clear_q[i] <= f_data;
        end
      end
    end
  end

  // ****************************************
  // Main control register
  // ****************************************
  // Bits 7 and 3..0 are not stored
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      idle_output_state_out <= `DWD_MAIN_RST;
      status_on_write_out <= `DWD_MAIN_RST;
      watchdog_on_out <= `DWD_MAIN_RST;
      timeout_sel_out <= 2'h0;
      short_limit_sel_out <= `DWD_MAIN_RST;
      global_output_on_out <= `DWD_MAIN_RST;
      global_boost_power_out <= 4'h0;
    end else if (main_we) begin
      idle_output_state_out <= f_data[`DWD_IDLE_BIT];
      status_on_write_out <= f_data[`DWD_STAT_BIT];
      watchdog_on_out <= f_data[`DWD_WD_ON_BIT];
      timeout_sel_out <= f_data[`DWD_TO_HI:`DWD_TO_LO];
      short_limit_sel_out <= f_data[`DWD_SHORT_BIT];
      global_output_on_out <= f_data[`DWD_OUT_ALL_BIT];
      global_boost_power_out <= {4{f_data[`DWD_BOOST_ALL_BIT]}};
    end
  end

  // Disabled voltage outputs take the pin level, inverted when set
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      idle_level_out <= 1'b0;
    end else begin
      idle_level_out <= idle_pin_s ^ idle_output_state_out;
    end
  end

  // ****************************************
  // Other control registers
  // ****************************************
  // Slew, channel, converter and software writes leave as a strobe;
  // the three spare sub-selects raise nothing
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_wr_out <= 1'b0;
      ctrl_sel_out <= 3'h0;
      ctrl_chan_out <= 2'h0;
      ctrl_data_out <= 13'h0000;
    end else begin
      ctrl_wr_out <= ctrl_we;
      if (ctrl_we) begin
        ctrl_sel_out <= f_creg;
        ctrl_chan_out <= f_ch;
        ctrl_data_out <= f_data[12:0];
      end
    end
  end

  // ****************************************
  // Interface watchdog
  // ****************************************
  reg [24:0] wd_cnt_q;
  reg [24:0] wd_limit;

  always @* begin
    case (timeout_sel_out)
      2'h0: wd_limit = WD_CYC0[24:0];
      2'h1: wd_limit = WD_CYC1[24:0];
      2'h2: wd_limit = WD_CYC2[24:0];
      default: wd_limit = WD_CYC3[24:0];
    endcase
  end

  // Limits are counted in clock cycles
  wire wd_run = watchdog_on_out && !commit;
  wire wd_hit = wd_run && (wd_cnt_q == wd_limit - 25'h0000001);
  wire wd_restart = !watchdog_on_out || commit || wd_hit;

  // Any accepted frame restarts the count; a frame accepted in the expiry cycle wins, so no expiry is flagged
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wd_cnt_q <= 25'h0000000;
      wd_expired_out <= 1'b0;
    end else begin
      if (wd_restart) begin
        wd_cnt_q <= 25'h0000000;
      end else begin
        wd_cnt_q <= wd_cnt_q + 25'h0000001;
      end
      if (wd_hit) begin
        wd_expired_out <= 1'b1;
      end else if (commit || !watchdog_on_out) begin
        wd_expired_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status readback
  // ****************************************
  // Status is framed at the start so it cannot tear mid-word;
  // the host samples each bit on the falling edge
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sdo_sh_q <= 24'h000000;
      sdo_oe_out <= 1'b0;
    end else begin
      // Drive only while the frame is open
      sdo_oe_out <= ~sync_n_s & status_on_write_out;
      if (frame_start) begin
        sdo_sh_q <= {3'h0, wd_expired_out, 4'h0, status_in};
      end else if (!sync_n_s && sclk_rise) begin
        sdo_sh_q <= {sdo_sh_q[22:0], 1'b0};
      end
    end
  end

  assign sdo_out = sdo_sh_q[23];
endmodule // dwd_write_decode

// file: bench/dwd_chk_sva.sv
module dwd_chk (
  input wire clk_in,
  input wire rst_n_in,
  input wire sync_n_in,
  input wire idle_pin_in,
  input wire sdo_oe_out,
  input wire [63:0] offset_out,
  input wire [63:0] clear_out,
  input wire idle_output_state_out,
  input wire status_on_write_out,
  input wire watchdog_on_out,
  input wire [1:0] timeout_sel_out,
  input wire short_limit_sel_out,
  input wire global_output_on_out,
  input wire [3:0] global_boost_power_out,
  input wire idle_level_out,
  input wire wd_expired_out,
  input wire ctrl_wr_out,
  input wire [2:0] ctrl_sel_out
);
  wire [10:0] main_v = {idle_output_state_out, status_on_write_out,
    watchdog_on_out, timeout_sel_out, short_limit_sel_out,
    global_output_on_out, global_boost_power_out};
  wire [138:0] st_v = {offset_out, clear_out, main_v};
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_reset_vals: assert property ($rose(rst_n_in) |->
    st_v == {{4{16'h8000}}, 64'h0, 11'h000}) else $error("bad reset value");
  chk_quiet_hold: assert property ($stable(sync_n_in)[*8] |->
    $stable(st_v)) else $error("register moved outside a frame");
  chk_ctrl_pulse: assert property (ctrl_wr_out |=> !ctrl_wr_out)
    else $error("control strobe too long");
  chk_ctrl_sel: assert property (ctrl_wr_out |->
    ctrl_sel_out inside {3'h0, 3'h2, 3'h3, 3'h4}) else $error("bad strobe");
  chk_boost_copy: assert property (
    global_boost_power_out inside {4'h0, 4'hF}) else $error("boost split");
  chk_idle_level: assert property (($stable(idle_pin_in) &&
    $stable(idle_output_state_out))[*5] |->
    idle_level_out == (idle_pin_in ^ idle_output_state_out))
    else $error("idle level wrong");
  chk_status_oe: assert property ($rose(sdo_oe_out) |->
    status_on_write_out) else $error("readback while disabled");
  chk_wd_off: assert property ((!watchdog_on_out)[*2] |->
    !wd_expired_out) else $error("expiry while watchdog off");
  cover property (ctrl_wr_out);
  cover property ($rose(wd_expired_out));
  cover property ($rose(sdo_oe_out));
endmodule // dwd_chk

bind dwd_write_decode dwd_chk chk_u (.clk_in, .rst_n_in, .sync_n_in,
  .idle_pin_in, .sdo_oe_out, .offset_out, .clear_out,
  .idle_output_state_out, .status_on_write_out, .watchdog_on_out,
  .timeout_sel_out, .short_limit_sel_out, .global_output_on_out,
  .global_boost_power_out, .idle_level_out, .wd_expired_out,
  .ctrl_wr_out, .ctrl_sel_out);

// file: bench/dwd_host.sv
module dwd_host (
  input wire clk_in,
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdin_out = 1'b0;
  end
  // Link clock stands high between frames; high phase alternates 6/7
  // cycles so the mean period is 125 ns
  task automatic send(input logic [23:0] w);
    integer i;
    repeat (2) @(posedge clk_in);
    sync_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (i = 23; i >= 0; i--) begin
      sdin_out <= w[i];
      sclk_out <= 1'b1;
      repeat (6 + i % 2) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
    sclk_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sync_n_out <= 1'b1;
    sdin_out <= ~sdin_out;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // dwd_host

// file: bench/dwd_write_decode_tb.sv
module dwd_write_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic idle_pin_in = 1'b0;
  logic [15:0] status_in = 16'h1234;
  logic [1:0] dev_q = 2'h2;
  logic [31:0] lfsr_q = 32'h0702;
  logic [15:0] off_m [4];
  logic [15:0] clr_m [4];
  logic [10:0] main_m = 11'h000;
  logic [138:0] st_q [$];
  logic [17:0] cw_q [$];
  logic [138:0] prev_q;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  integer lim [4] = '{50, 100, 200, 400};
  wire sclk, sync_n, sdin, idle_st, stat_on, wd_on, shrt, out_all, cw;
  wire idle_lvl, wd_exp;
  wire [63:0] offs, clrs;
  wire [1:0] to_sel, c_ch;
  wire [3:0] boost;
  wire [2:0] c_sel;
  wire [12:0] c_dat;
  wire [138:0] cur_st = {offs, clrs, idle_st, stat_on, wd_on, to_sel, shrt,
    out_all, boost};
  always #5 clk_in = ~clk_in;
  dwd_host host_u (.clk_in(clk_in), .sclk_out(sclk), .sync_n_out(sync_n),
    .sdin_out(sdin));
  dwd_write_decode #(.WD_CYC0(50), .WD_CYC1(100), .WD_CYC2(200),
    .WD_CYC3(400)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .sync_n_in(sync_n), .sdin_in(sdin),
    .device_select_hi_in(dev_q[1]), .device_select_lo_in(dev_q[0]),
    .idle_pin_in(idle_pin_in), .status_in(status_in), .sdo_out(),
    .sdo_oe_out(), .offset_out(offs), .clear_out(clrs),
    .idle_output_state_out(idle_st), .status_on_write_out(stat_on),
    .watchdog_on_out(wd_on), .timeout_sel_out(to_sel),
    .short_limit_sel_out(shrt), .global_output_on_out(out_all),
    .global_boost_power_out(boost), .idle_level_out(idle_lvl),
    .wd_expired_out(wd_exp), .ctrl_wr_out(cw), .ctrl_sel_out(c_sel),
    .ctrl_chan_out(c_ch), .ctrl_data_out(c_dat));
  // ****************************************
  // Model and checks
  // ****************************************
  function automatic logic [138:0] model();
    for (int k = 0; k < 4; k++) begin
      model[138 - 16 * k -: 16] = off_m[3 - k];
      model[74 - 16 * k -: 16] = clr_m[3 - k];
    end
    model[10:0] = main_m;
  endfunction
  function automatic logic [23:0] fr(logic [2:0] d, logic [1:0] c,
    logic [15:0] v);
    return {1'b0, dev_q, d, c, v};
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(string nm, logic [138:0] e, logic [138:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic put(logic [23:0] w);
    logic [138:0] old;
    old = model();
    if (w[23:21] == {1'b0, dev_q}) begin
      case (w[20:18])
        3'h4: off_m[w[17:16]] = w[15:0];
        3'h5: for (int k = 0; k < 4; k++) off_m[k] = w[15:0];
        3'h6: clr_m[w[17:16]] = w[15:0];
        3'h7: if (w[15:13] == 3'h1) main_m = {w[12:8], w[6:5], {4{w[4]}}};
          else if (w[15:13] < 3'h5)
            cw_q.push_back({w[15:13], w[17:16], w[12:0]});
        default: ;
      endcase
    end
    if (model() !== old) st_q.push_back(model());
    host_u.send(w);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Each visible change or strobe consumes the oldest note
  always @(posedge clk_in) begin
    prev_q <= cur_st;
    if (rst_n_in && cur_st !== prev_q)
      cmp("state", st_q.size() ? st_q.pop_front() : ~cur_st, cur_st);
    if (rst_n_in && cw === 1'b1)
      cmp("ctrl", cw_q.size() ? cw_q.pop_front() : ~{c_sel, c_ch, c_dat},
        {c_sel, c_ch, c_dat});
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    for (i = 0; i < 4; i++) begin
      off_m[i] = 16'h8000;
      clr_m[i] = 16'h0000;
    end
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    cmp("reset", model(), cur_st);
    for (i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      put(fr(3'h4, i[1:0], lfsr_q[15:0]));
      put(fr(3'h6, i[1:0], lfsr_q[31:16]));
    end
    put(fr(3'h4, 2'h3, 16'hFFFF));
    put(fr(3'h4, 2'h0, 16'h0000));
    put(fr(3'h5, 2'h1, lfsr_q[15:0]));
    for (i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      put(fr(3'h7, lfsr_q[17:16], {i[2:0], lfsr_q[12:0]}));
      idle_pin_in <= lfsr_q[20];
    end
    put({1'b1, dev_q, 3'h4, 18'h0ABCD});
    put({1'b0, ~dev_q, 3'h4, 18'h0ABCD});
    for (i = 0; i < 4; i++) put(fr(i[2:0], 2'h0, 16'h1357));
    for (i = 0; i < 2; i++) begin
      put(fr(3'h7, 2'h0, {3'h1, i[0], 12'h800}));
      idle_pin_in <= ~idle_pin_in;
      repeat (8) @(posedge clk_in);
      cmp("idle", idle_pin_in ^ i[0], idle_lvl);
    end
    for (i = 0; i < 4; i++) begin
      put(fr(3'h7, 2'h0, {6'h09, i[1:0], 8'h70}));
      repeat (lim[i] - 12) @(posedge clk_in);
      cmp("wd_early", 0, wd_exp);
      repeat (24) @(posedge clk_in);
      cmp("wd_late", 1, wd_exp);
    end
    // Outputs go off before the converters are powered down
    put(fr(3'h7, 2'h0, 16'h2010));
    put(fr(3'h7, 2'h0, 16'h2000));
    repeat (10) @(posedge clk_in);
    cmp("notes_left", 0, st_q.size() + cw_q.size());
    print_verdict();
  end
endmodule // dwd_write_decode_tb
